// ---- epi_unit.sv ----
// Purpose: External pin interrupt unit with AXI4-Lite registers
// Assumes: Pins are read at the pad, whatever the port direction
// Notes: Inputs 3..0 captured without clock; 7..4 sampled on aclk
// Function
// - Pins raise requests even when driven outputs
// - Any selected group pin toggle raises request
// - Pin-change detection needs no running clock
// - Enabled low level requests while pin low
// - Inputs 7..4 edges need running clock
// - Low level request can wake deep sleep
// - Vanished wake level wakes, no interrupt
// - Request acts only with global and enable
// - Inputs 3..0 capture edges asynchronously
// - Inputs 3..0 decode low/any/fall/rise
// - Inputs 7..4 decode low/change/fall/rise sampled
// - Inputs 7..4 sampled before edge detection
// - Writing one clears a flag
// - One enable bit per dedicated input
// - Sense pairs in two registers, inputs 3..0 first
// - Flag set on event, cleared on vector
// - Flag held clear in level mode
// - Group request needs mask and group enable
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module epi_unit #(parameter int NPINS = 8)
(
   input wire logic aclk, // System clock
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic [31:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [31:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read valid
   input wire logic s_axi_rready, // Read ready
   input wire logic [7:0] dedicated_irq_pins, // Dedicated pad levels
   input wire logic [NPINS-1:0] pin_change_inputs, // Group pad levels
   input wire logic global_irq_enable, // Status word interrupt bit
   output logic [7:0] dedicated_irq_req, // Per-input requests to vectoring
   output logic pin_change_group_request, // Group request to vectoring
   output logic wake_request // Asynchronous wake from sleep
);
   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   logic [7:0] low_sense_control_r;
   logic [7:0] high_sense_control_r;
   logic [7:0] pin_irq_enable_mask_r;
   logic [7:0] pin_irq_flags_r;
   logic pin_change_group_enable_r;
   logic [NPINS-1:0] pin_change_select_mask_r;
   logic pc_flag_r;
   logic [7:0] hi_samp_r;
   logic [7:0] hi_prev_r;
   logic [3:0] async_evt;
   logic [3:0] async_wake;
   logic pc_evt;
   logic pc_wake;
   logic [7:0] edge_evt;
   logic [7:0] level_mode;
   logic [7:0] lvl_now;
   logic [15:0] sense_all;
   // Write channel state
   logic aw_hold_r;
   logic w_hold_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic wr_go;
   logic wr_hit;
   logic [7:0] flag_clr;
   logic [7:0] vec_ack;
   logic pc_clr;
   logic pc_ack;
   logic [31:0] rd_val;
   logic rd_hit;

   assign sense_all = {high_sense_control_r, low_sense_control_r};

   // -----------------------------------------------------------------
   // Asynchronous capture, inputs 3..0; group detector with clockless wake
   // -----------------------------------------------------------------
   genvar n;
   generate
      for (n = 0; n < 4; n++)
      begin : g_async
         epi_async_edge u_edge
         (
            .aclk(aclk),
            .aresetn(aresetn),
            .pin(dedicated_irq_pins[n]),
            .sense(sense_all[2*n+1:2*n]),
            .event_pulse(async_evt[n]),
            .wake(async_wake[n])
         );
      end
   endgenerate

   epi_pin_change #(.WIDTH(NPINS)) u_pc
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .pins(pin_change_inputs),
      .select(pin_change_select_mask_r),
      .change_pulse(pc_evt),
      .wake(pc_wake)
   );

   // -----------------------------------------------------------------
   // Sampled inputs 7..4 and event decode
   // -----------------------------------------------------------------
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         // Start from the pads so leaving reset shows no edge
         hi_samp_r <= dedicated_irq_pins;
         hi_prev_r <= dedicated_irq_pins;
      end
      else
      begin
         hi_samp_r <= dedicated_irq_pins;
         hi_prev_r <= hi_samp_r;
      end

   generate
      for (n = 0; n < 8; n++)
      begin : g_dec
         assign level_mode[n] = sense_all[2*n+1:2*n] == epi_pkg::SENSE_LOW;
         // Level request follows the live pad so a vanished level makes none
         assign lvl_now[n] = level_mode[n] & ~dedicated_irq_pins[n];
         if (n < 4)
         begin : g_lo
            assign edge_evt[n] = async_evt[n] & ~level_mode[n];
         end
         else
         begin : g_hi
            always_comb
            begin
               unique case (sense_all[2*n+1:2*n])
                  epi_pkg::SENSE_ANY: edge_evt[n] = hi_samp_r[n] ^ hi_prev_r[n];
                  epi_pkg::SENSE_FALL: edge_evt[n] = hi_prev_r[n] & ~hi_samp_r[n];
                  epi_pkg::SENSE_RISE: edge_evt[n] = ~hi_prev_r[n] & hi_samp_r[n];
                  default: edge_evt[n] = 1'b0;
               endcase
            end
         end
      end
   endgenerate

   // -----------------------------------------------------------------
   // Flags: set beats clear
   // -----------------------------------------------------------------
   always_ff @(posedge aclk)
      if (!aresetn)
         pin_irq_flags_r <= epi_pkg::RST_BYTE;
      else
         pin_irq_flags_r <= (edge_evt | (pin_irq_flags_r & ~flag_clr & ~vec_ack))
                            & ~level_mode;

   always_ff @(posedge aclk)
      if (!aresetn)
         pc_flag_r <= 1'b0;
      else
         pc_flag_r <= pc_evt | (pc_flag_r & ~pc_clr & ~pc_ack);

   // -----------------------------------------------------------------
   // Requests and wake
   // -----------------------------------------------------------------
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         dedicated_irq_req <= epi_pkg::RST_BYTE;
         pin_change_group_request <= 1'b0;
      end
      else
      begin
         dedicated_irq_req <= (pin_irq_flags_r | lvl_now)
                              & pin_irq_enable_mask_r
                              & {8{global_irq_enable}};
         pin_change_group_request <= pc_flag_r & pin_change_group_enable_r
                                     & global_irq_enable;
      end

   // Combinational so it works with the clock stopped
   assign wake_request = |(pin_irq_enable_mask_r & (lvl_now | {4'h0, async_wake}))
                         | (pc_wake & pin_change_group_enable_r);

   // -----------------------------------------------------------------
   // AXI4-Lite write path
   // -----------------------------------------------------------------
   assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
   assign s_axi_wready = ~w_hold_r & ~s_axi_bvalid;
   assign wr_go = aw_hold_r & w_hold_r;

   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr[7:0];
         end
         else if (wr_go)
            aw_hold_r <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         else if (wr_go)
            w_hold_r <= 1'b0;
      end

   always_comb
   begin
      unique case (aw_addr_r)
         epi_pkg::OFS_LOW_SENSE, epi_pkg::OFS_HIGH_SENSE, epi_pkg::OFS_ENABLE,
         epi_pkg::OFS_FLAGS, epi_pkg::OFS_PC_CTRL, epi_pkg::OFS_PC_MASK,
         epi_pkg::OFS_PC_FLAG, epi_pkg::OFS_VECTOR_ACK: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // Strobes for clear-on-write and vector acknowledge
   assign flag_clr = (wr_go && aw_addr_r == epi_pkg::OFS_FLAGS && w_strb_r[0])
                     ? w_data_r[7:0] : 8'h00;
   assign vec_ack = (wr_go && aw_addr_r == epi_pkg::OFS_VECTOR_ACK && w_strb_r[0])
                    ? w_data_r[7:0] : 8'h00;
   assign pc_clr = wr_go && aw_addr_r == epi_pkg::OFS_PC_FLAG && w_strb_r[0]
                   && w_data_r[epi_pkg::PC_FLAG_BIT];
   assign pc_ack = wr_go && aw_addr_r == epi_pkg::OFS_VECTOR_ACK && w_strb_r[1]
                   && w_data_r[epi_pkg::VEC_PC_BIT];

   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         low_sense_control_r <= epi_pkg::RST_BYTE;
         high_sense_control_r <= epi_pkg::RST_BYTE;
         pin_irq_enable_mask_r <= epi_pkg::RST_BYTE;
         pin_change_group_enable_r <= 1'b0;
         pin_change_select_mask_r <= '0;
      end
      else if (wr_go && w_strb_r[0])
      begin
         unique case (aw_addr_r)
            epi_pkg::OFS_LOW_SENSE: low_sense_control_r <= w_data_r[7:0];
            epi_pkg::OFS_HIGH_SENSE: high_sense_control_r <= w_data_r[7:0];
            epi_pkg::OFS_ENABLE: pin_irq_enable_mask_r <= w_data_r[7:0];
            epi_pkg::OFS_PC_CTRL:
               pin_change_group_enable_r <= w_data_r[epi_pkg::PC_ENABLE_BIT];
            epi_pkg::OFS_PC_MASK: pin_change_select_mask_r <= w_data_r[NPINS-1:0];
            default: ;
         endcase
      end

   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= epi_pkg::RESP_OKAY;
      end
      else if (wr_go)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? epi_pkg::RESP_OKAY : epi_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;

   // -----------------------------------------------------------------
   // AXI4-Lite read path
   // -----------------------------------------------------------------
   assign s_axi_arready = ~s_axi_rvalid;

   always_comb
   begin
      rd_val = 32'h0000_0000;
      rd_hit = 1'b1;
      unique case (s_axi_araddr[7:0])
         epi_pkg::OFS_LOW_SENSE: rd_val[7:0] = low_sense_control_r;
         epi_pkg::OFS_HIGH_SENSE: rd_val[7:0] = high_sense_control_r;
         epi_pkg::OFS_ENABLE: rd_val[7:0] = pin_irq_enable_mask_r;
         epi_pkg::OFS_FLAGS: rd_val[7:0] = pin_irq_flags_r;
         epi_pkg::OFS_PC_CTRL: rd_val[epi_pkg::PC_ENABLE_BIT] = pin_change_group_enable_r;
         epi_pkg::OFS_PC_MASK: rd_val[NPINS-1:0] = pin_change_select_mask_r;
         epi_pkg::OFS_PC_FLAG: rd_val[epi_pkg::PC_FLAG_BIT] = pc_flag_r;
         epi_pkg::OFS_VECTOR_ACK: rd_val = 32'h0000_0000;
         epi_pkg::OFS_PIN_STATE: rd_val[7:0] = dedicated_irq_pins;
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= epi_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_val;
         s_axi_rresp <= rd_hit ? epi_pkg::RESP_OKAY : epi_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
endmodule // epi_unit
`default_nettype wire

// ---- epi_pkg.sv ----
// Purpose: Shared constants for the external pin interrupt unit
// Assumes: 32-bit AXI4-Lite register access, 25 MHz clock
// Notes: Offsets are byte addresses on aligned words
package epi_pkg;
   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam logic [7:0] OFS_LOW_SENSE = 8'h00;
   localparam logic [7:0] OFS_HIGH_SENSE = 8'h04;
   localparam logic [7:0] OFS_ENABLE = 8'h08;
   localparam logic [7:0] OFS_FLAGS = 8'h0c;
   localparam logic [7:0] OFS_PC_CTRL = 8'h10;
   localparam logic [7:0] OFS_PC_MASK = 8'h14;
   localparam logic [7:0] OFS_PC_FLAG = 8'h18;
   localparam logic [7:0] OFS_VECTOR_ACK = 8'h1c;
   localparam logic [7:0] OFS_PIN_STATE = 8'h20;
   // -----------------------------------------------------------------
   // Reset values and field positions
   // -----------------------------------------------------------------
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam int PC_ENABLE_BIT = 0;
   localparam int PC_FLAG_BIT = 0;
   localparam int VEC_PC_BIT = 8;
   // Sense field encodings
   localparam logic [1:0] SENSE_LOW = 2'h0;
   localparam logic [1:0] SENSE_ANY = 2'h1;
   localparam logic [1:0] SENSE_FALL = 2'h2;
   localparam logic [1:0] SENSE_RISE = 2'h3;
   // Pulse width that the asynchronous capture must accept
   localparam int MIN_PULSE_NS = 50;
   localparam int CLK_PERIOD_NS = 40;
   localparam int MIN_PULSE_CYC = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- epi_async_edge.sv ----
// Purpose: Clockless edge capture for one dedicated input
// Assumes: Capture latch is cleared through the handshake ack
// Notes: Works with the clock stopped, so it can wake the core
`timescale 1ns/1ps
`default_nettype none
module epi_async_edge
(
   input wire logic aclk, // System clock
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic pin, // Raw pin level
   input wire logic [1:0] sense, // Sense selection
   output logic event_pulse, // One-cycle event in clock domain
   output logic wake // Asynchronous pending, for wake logic
);
   logic cap_r;
   logic ack_r;
   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic edge_clk;
   logic clr;

   // Pin acts as a clock: rising and falling captured on separate phases
   logic rise_r;
   logic fall_r;
   assign clr = ack_r;
   always_ff @(posedge pin or posedge clr)
      if (clr)
         rise_r <= 1'b0;
      else
         rise_r <= 1'b1;
   always_ff @(negedge pin or posedge clr)
      if (clr)
         fall_r <= 1'b0;
      else
         fall_r <= 1'b1;

   always_comb
   begin
      unique case (sense)
         epi_pkg::SENSE_ANY: cap_r = rise_r | fall_r;
         epi_pkg::SENSE_FALL: cap_r = fall_r;
         epi_pkg::SENSE_RISE: cap_r = rise_r;
         default: cap_r = 1'b0;
      endcase
   end
   assign edge_clk = cap_r;
   assign wake = cap_r;

   // Two-stage synchroniser, then a third stage for the pulse
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end
      else
      begin
         s1_r <= edge_clk;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   // Ack clears the latches once the event is safely in the clock domain
   always_ff @(posedge aclk)
      if (!aresetn)
         ack_r <= 1'b1;
      else
         ack_r <= s2_r;
   assign event_pulse = s2_r & ~s3_r;
endmodule // epi_async_edge
`default_nettype wire

// ---- epi_pin_change.sv ----
// Purpose: Pin-change detector for the group, with a clockless wake
// Assumes: Mask applied after the detector, so mask writes make no event
// Notes: Wake compares the live pads with the last settled copy
`timescale 1ns/1ps
`default_nettype none
module epi_pin_change #(parameter int WIDTH = 8)
(
   input wire logic aclk, // System clock
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic [WIDTH-1:0] pins, // Raw group pins
   input wire logic [WIDTH-1:0] select, // Per-pin mask
   output logic change_pulse, // One-cycle change event
   output logic wake // Asynchronous change pending
);
   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] seen_r;
   // Copies load the pads in reset, so leaving reset shows no change
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         s1_r <= pins;
         s2_r <= pins;
         seen_r <= pins;
      end
      else
      begin
         s1_r <= pins;
         s2_r <= s1_r;
         seen_r <= s2_r;
      end
   assign change_pulse = |((s2_r ^ seen_r) & select);
   // The copy holds still while the clock is stopped, so a toggle still wakes
   assign wake = |((pins ^ seen_r) & select);
endmodule // epi_pin_change
`default_nettype wire

// ---- epi_unit_assertions.sv ----
// Purpose: Port checker for the pin interrupt unit
// Assumes: Master keeps one write and one read in flight
// Notes: Bound to every epi_unit instance
`timescale 1ns/1ps
`default_nettype none
module epi_unit_chk
(
   input wire logic aclk, // Clock
   input wire logic aresetn, // Reset, active low
   input wire logic s_axi_awvalid, // AW valid
   input wire logic s_axi_awready, // AW ready
   input wire logic s_axi_wvalid, // W valid
   input wire logic s_axi_wready, // W ready
   input wire logic s_axi_bvalid, // B valid
   input wire logic s_axi_bready, // B ready
   input wire logic [31:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // AR valid
   input wire logic s_axi_arready, // AR ready
   input wire logic [1:0] s_axi_rresp, // Read response
   input wire logic s_axi_rvalid, // R valid
   input wire logic s_axi_rready, // R ready
   input wire logic global_irq_enable, // Global enable
   input wire logic [7:0] dedicated_irq_req, // Requests
   input wire logic pin_change_group_request // Group request
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_gie_gates_req: assert property (!global_irq_enable |=> dedicated_irq_req == 8'h00)
      else $error("request while globally disabled");
   a_gie_gates_grp: assert property (!global_irq_enable |=> !pin_change_group_request)
      else $error("group request while globally disabled");
   a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read data dropped early");
   a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while answer pending");
   a_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_wr_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
   a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready &&
      s_axi_araddr[31:8] == 24'h0 && s_axi_araddr[7:0] > 8'h20 |=>
      s_axi_rresp == epi_pkg::RESP_SLVERR)
      else $error("unmapped read not refused");

   c_ded_req: cover property (dedicated_irq_req != 8'h00);
   c_grp_req: cover property (pin_change_group_request);
   c_unmapped: cover property (s_axi_rvalid && s_axi_rresp == epi_pkg::RESP_SLVERR);
endmodule // epi_unit_chk

bind epi_unit epi_unit_chk u_chk
(
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .global_irq_enable(global_irq_enable), .dedicated_irq_req(dedicated_irq_req),
   .pin_change_group_request(pin_change_group_request)
);
`default_nettype wire

// ---- epi_pin_model.sv ----
// Purpose: Pads and status word seen by the pin interrupt unit
// Assumes: Tasks are called right after a rising clock edge
// Notes: Pads are driven like port outputs, the software trigger case
`timescale 1ns/1ps
`default_nettype none
module epi_pin_model
(
   output logic [7:0] ded_pins, // Dedicated pads
   output logic [7:0] pc_pins, // Group pads
   output logic gie // Global enable
);
   initial
   begin
      ded_pins = 8'hff;
      pc_pins = 8'h00;
      gie = 1'b0;
   end
   // Level holds until released, as a source waiting for the core must
   task automatic set_level(input int i, input logic v);
      ded_pins[i] <= v;
   endtask
   // Free width, so both narrow and slow pulses can be offered
   task automatic pulse(input int i, input int ns);
      ded_pins[i] <= 1'b0;
      #(ns);
      ded_pins[i] <= 1'b1;
   endtask
   task automatic toggle_pc(input int i);
      pc_pins[i] <= ~pc_pins[i];
   endtask
   task automatic set_gie(input logic v);
      gie <= v;
   endtask
endmodule // epi_pin_model
`default_nettype wire

// ---- external_pin_interrupt_unit_tb.sv ----
// Purpose: Self-checking bench for the pin interrupt unit
// Assumes: Partner model drives all pads and the global enable
// Notes: Fixed waits after pad activity cover the flag latencies
`timescale 1ns/1ps
`default_nettype none
module external_pin_interrupt_unit_tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, grp, wake, gie;
   logic [1:0] bresp, rresp;
   logic [7:0] ded, pcp, req;
   logic [3:0] wstrb = 4'hf;
   int miscompares = 0;
   int checks_done = 0;

   always #20 aclk = ~aclk;

   epi_unit dut
   (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .dedicated_irq_pins(ded), .pin_change_inputs(pcp), .global_irq_enable(gie),
      .dedicated_irq_req(req), .pin_change_group_request(grp), .wake_request(wake)
   );
   epi_pin_model pm (.ded_pins(ded), .pc_pins(pcp), .gie(gie));

   function automatic logic [31:0] b1(input logic x);
      return {31'h0, x};
   endfunction
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   // Handshakes are judged at the falling edge, the value the next rising edge samples
   task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] q,
      output logic [1:0] r);
      int n;
      logic b, v, ta, tw, tr;
      n = 0;
      b = 1'b0;
      v = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      araddr <= a;
      wdata <= d;
      awvalid <= w;
      wvalid <= w;
      bready <= w;
      arvalid <= !w;
      rready <= !w;
      while (!(b | v) && n < 30)
      begin
         @(negedge aclk);
         q = rdata;
         r = w ? bresp : rresp;
         b = bvalid & bready;
         v = rvalid & rready;
         ta = awvalid & awready;
         tw = wvalid & wready;
         tr = arvalid & arready;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tr) arvalid <= 1'b0;
         if (b) bready <= 1'b0;
         if (v) rready <= 1'b0;
         n++;
      end
      if (!(b | v))
      begin
         miscompares++;
         report_and_stop();
      end
   endtask
   task automatic wrr(input logic [31:0] a, d);
      logic [31:0] q;
      logic [1:0] r;
      bus(1'b1, a, d, q, r);
      check("bresp", 32'(r), 32'(epi_pkg::RESP_OKAY));
   endtask
   task automatic rdc(input string nm, input logic [31:0] a, e);
      logic [31:0] q;
      logic [1:0] r;
      bus(1'b0, a, 32'h0, q, r);
      check(nm, q, e);
   endtask

   task automatic t_regs();
      logic [31:0] q;
      logic [1:0] r;
      for (int a = 0; a < 32; a += 4)
         rdc("reset value", 32'(a), 32'h0);
      wrr(32'h04, 32'hffffffa5);
      rdc("high sense", 32'h04, 32'ha5);
      wrr(32'h08, 32'h5a);
      rdc("enable mask", 32'h08, 32'h5a);
      wstrb <= 4'h0;
      wrr(32'h08, 32'hff);
      wstrb <= 4'hf;
      rdc("strobe gated", 32'h08, 32'h5a);
      wrr(32'h0c, 32'hff);
      rdc("flags w1c", 32'h0c, 32'h0);
      bus(1'b0, 32'h24, 32'h0, q, r);
      check("unmapped resp", 32'(r), 32'(epi_pkg::RESP_SLVERR));
      wrr(32'h08, 32'h0);
      $display("t_regs done");
   endtask
   task automatic t_edges(input int i);
      logic [31:0] sa;
      sa = (i > 3) ? 32'h04 : 32'h00;
      for (int m = 1; m < 4; m++)
      begin
         wrr(32'h08, 32'h0);
         wrr(sa, 32'(m) << ((i % 4) * 2));
         wait_cyc(6);
         wrr(32'h0c, 32'hff);
         wrr(32'h08, 32'h1 << i);
         pm.set_level(i, 1'b0);
         wait_cyc(6);
         rdc("flag after fall", 32'h0c, b1(m != 3) << i);
         check("req after fall", b1(req[i]), b1(m != 3));
         wrr(32'h1c, 32'h1 << i);
         pm.set_level(i, 1'b1);
         wait_cyc(6);
         rdc("flag after rise", 32'h0c, b1(m != 2) << i);
         wrr(32'h0c, 32'h1 << i);
         rdc("flag cleared", 32'h0c, 32'h0);
      end
      $display("t_edges %0d done", i);
   endtask
   task automatic t_pulses();
      wrr(32'h08, 32'h0);
      wrr(32'h00, 32'h2);
      wrr(32'h04, 32'h30);
      wait_cyc(6);
      wrr(32'h0c, 32'hff);
      wrr(32'h08, 32'h41);
      pm.pulse(0, 60);
      pm.pulse(6, 90);
      wait_cyc(6);
      rdc("pulse flags", 32'h0c, 32'h41);
      wrr(32'h08, 32'h0);
      wrr(32'h0c, 32'h41);
      $display("t_pulses done");
   endtask
   task automatic t_level();
      wrr(32'h00, 32'h0);
      wrr(32'h08, 32'h4);
      pm.set_level(2, 1'b0);
      wait_cyc(4);
      check("level req", b1(req[2]), 32'h1);
      check("level wake", b1(wake), 32'h1);
      wait_cyc(8);
      check("level req held", b1(req[2]), 32'h1);
      rdc("level flag", 32'h0c, 32'h0);
      pm.set_gie(1'b0);
      wait_cyc(2);
      check("req masked", 32'(req), 32'h0);
      pm.set_gie(1'b1);
      pm.set_level(2, 1'b1);
      wait_cyc(3);
      check("level gone", b1(req[2]), 32'h0);
      wrr(32'h08, 32'h0);
      $display("t_level done");
   endtask
   task automatic t_pc();
      wrr(32'h14, 32'h08);
      wait_cyc(6);
      wrr(32'h18, 32'h1);
      wrr(32'h10, 32'h1);
      pm.toggle_pc(4);
      wait_cyc(6);
      rdc("unselected toggle", 32'h18, 32'h0);
      pm.toggle_pc(3);
      wait_cyc(1);
      check("group wake", b1(wake), 32'h1);
      wait_cyc(5);
      rdc("selected toggle", 32'h18, 32'h1);
      check("group req", b1(grp), 32'h1);
      wrr(32'h1c, 32'h100);
      wait_cyc(2);
      rdc("group flag acked", 32'h18, 32'h0);
      check("group req gone", b1(grp), 32'h0);
      $display("t_pc done");
   endtask

   initial
   begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      pm.set_gie(1'b1);
      t_regs();
      t_edges(5);
      t_edges(1);
      t_pulses();
      t_level();
      t_pc();
      report_and_stop();
   end
endmodule // external_pin_interrupt_unit_tb
`default_nettype wire
